// ---- design/fllcg_pkg.sv ----
// constants, register map and mode encoding of the fll clock generator
package fllcg_pkg;
   // register indices on the plain port
   localparam logic [2:0] OFS_CTRL      = 3'h0;
   localparam logic [2:0] OFS_LOOP      = 3'h1;
   localparam logic [2:0] OFS_STATUS    = 3'h2;
   localparam logic [2:0] OFS_FILT_HI   = 3'h3;
   localparam logic [2:0] OFS_FILT_LO   = 3'h4;
   localparam logic [2:0] OFS_TRIM      = 3'h5;
   // control and loop register fields
   localparam int CTRL_MODE_LSB  = 0;
   localparam int CTRL_REFSEL    = 2;
   localparam int CTRL_RANGE     = 3;
   localparam int CTRL_KEEP      = 4;
   localparam int LOOP_MULT_LSB  = 0;
   localparam int LOOP_DIVR_LSB  = 4;
   // status register fields
   localparam int STAT_MODE_LSB  = 0;
   localparam int STAT_LOCK      = 2;
   localparam int STAT_LOSS      = 3;
   localparam int STAT_EXT       = 4;
   localparam int STAT_STABLE    = 5;
   // values after reset
   localparam logic [1:0]  MODE_SEL_RESET = 2'h0;
   localparam logic [2:0]  MULT_RESET     = 3'h0;
   localparam logic [2:0]  DIVR_RESET     = 3'h1;
   localparam logic [11:0] FILTER_RESET   = 12'h200;
   localparam logic [7:0]  TRIM_POR       = 8'h80;
   // mode select codes
   localparam logic [1:0] SEL_SELF      = 2'h0;
   localparam logic [1:0] SEL_INT_LOCK  = 2'h1;
   localparam logic [1:0] SEL_BYPASS    = 2'h2;
   localparam logic [1:0] SEL_EXT_LOCK  = 2'h3;
   // crystal start-up count and lock detector figures
   localparam logic [12:0] XTAL_COUNT   = 13'h1000;
   localparam logic [7:0]  LOCK_WIN     = 8'h02;
   localparam logic [7:0]  UNLOCK_WIN   = 8'h08;
   localparam logic [2:0]  LOCK_SAMPLES = 3'h4;
   localparam logic [1:0]  AVG_LAST     = 2'h3;
   // gray coded along scm -> fei -> fee -> fbe -> off
   typedef enum logic [2:0] {
      ST_SCM = 3'b000,
      ST_FEI = 3'b001,
      ST_FEE = 3'b011,
      ST_FBE = 3'b010,
      ST_OFF = 3'b110
   } fllcg_state_e;
endpackage : fllcg_pkg

// ---- design/fllcg_clock_generator.sv ----
// clock_generator mode controller with filter, lock detector and registers
//
// Function
// - trim field scales internal reference period; larger value, longer period
// - entering stop stops all clocks and goes off unless debug or keep set
// - with background debug enabled the generator keeps running through stop
// - keep-in-stop leaves sources running but gates the delivered clock off
// - interrupt wake keeps settings; locked-external runs internal until ready
// - interrupt wake into bypass-external holds output until external ready
// - reset loads defaults, starts self-clocked at nominal filter, trim kept
// - a crystal needs 4096 external cycles before it is used
// - self-clocked entry: reset, off exit, X1 to 00, lost external clock
// - self-clocked: loop open, oscillator on; filter writable only here
// - filter kept on mode entry; leaving unlocked external doubles output
// - off exit with 01 or 11 waits for stable oscillator, then closes loop
// - locked-internal entered on select 01 or stable after off with 01
// - locked-internal uses internal reference and the multiplier field
// - unlocked when error leaves unlock window, held until inside lock window
// - locked after enough samples inside; filter then updated by 4-average
// - bypass-external entry: select 10 with ext, off exit, oscillator loss
// - bypass-external: oscillator and internal reference off, output ext/R
// - source select 0 direct clock, 1 crystal; range bit low 0, high 1
// - lock flag reads zero in off, self-clocked and bypass-external
// - oscillator-stable flag clears whenever off is entered
// - locked-external entered on select 11 with ext and stable flags high
`timescale 1ns/10ps
module fllcg_clock_generator (
   input  wire logic              clock,
   input  wire logic              rst,
   input  wire logic              por,
   input  wire logic [2:0]        addr,
   input  wire logic [7:0]        wdata,
   input  wire logic              wr,
   input  wire logic              rd,
   output logic      [7:0]        rdata,
   input  wire logic              stop_req,
   input  wire logic              background_debug_mode,
   input  wire logic              dco_stable_in,
   input  wire logic              ext_clk_ok,
   input  wire logic              ext_clk_tick,
   input  wire logic              loss_event,
   input  wire logic              err_valid,
   input  wire logic signed [7:0] count_err,
   output logic                   osc_enable,
   output logic                   irg_enable,
   output logic                   ext_osc_enable,
   output logic                   ref_source_select,
   output logic                   ext_range_high,
   output logic                   loop_closed,
   output logic                   loop_ref_external,
   output logic      [2:0]        loop_multiplier,
   output logic      [2:0]        out_div_r,
   output logic                   out_from_ext,
   output logic                   out_div_by2,
   output logic                   gen_clk_enable,
   output logic      [11:0]       filter_value,
   output logic      [7:0]        trim_value
);
   fllcg_pkg::fllcg_state_e state_reg, state_next;
   logic [1:0]  mode_sel_reg;
   logic        refsel_reg, range_reg, keep_reg;
   logic [2:0]  mult_reg, divr_reg;
   logic [11:0] filter_reg, filter_next;
   logic [7:0]  filt_stage_reg;
   logic [7:0]  trim_reg;
   logic        stable_reg, loss_reg, ext_at_off_reg, off_exit_reg;
   logic        locked_reg, ever_locked_reg;
   logic [2:0]  lock_cnt_reg;
   logic [1:0]  avg_cnt_reg;
   logic signed [9:0] avg_acc_reg;
   logic [12:0] xtal_cnt_reg;
   logic [7:0]  rdata_reg;

   // decode
   wire wr_ctrl   = wr && addr == fllcg_pkg::OFS_CTRL;
   wire wr_loop   = wr && addr == fllcg_pkg::OFS_LOOP;
   wire wr_status = wr && addr == fllcg_pkg::OFS_STATUS;
   wire wr_fhi    = wr && addr == fllcg_pkg::OFS_FILT_HI;
   wire wr_flo    = wr && addr == fllcg_pkg::OFS_FILT_LO;
   wire wr_trim   = wr && addr == fllcg_pkg::OFS_TRIM;

   wire in_loop   = state_reg == fllcg_pkg::ST_FEI ||
                    state_reg == fllcg_pkg::ST_FEE;
   wire go_off    = stop_req && !background_debug_mode && !keep_reg;
   wire stop_gate = stop_req && !background_debug_mode && keep_reg;
   wire filt_open = state_reg == fllcg_pkg::ST_SCM &&
                    mode_sel_reg == fllcg_pkg::SEL_SELF;
   // a crystal is trusted only after its start-up count has run out
   wire xtal_done = xtal_cnt_reg == fllcg_pkg::XTAL_COUNT;
   wire ext_ready = ext_clk_ok && (!refsel_reg || xtal_done);
   wire sel_ext   = mode_sel_reg[1];
   wire lost_ext  = sel_ext && !ext_ready && loss_reg;

   wire [7:0] err_mag = count_err[7] ? 8'(-count_err) : 8'(count_err);
   wire in_lock_win   = err_mag <= fllcg_pkg::LOCK_WIN;
   wire in_unlock_win = err_mag <= fllcg_pkg::UNLOCK_WIN;
   wire signed [9:0] avg_sum = avg_acc_reg + 10'(count_err);

   // read selection
   wire [1:0] mode_code = state_reg == fllcg_pkg::ST_FEI ? 2'h1 :
                          state_reg == fllcg_pkg::ST_FBE ? 2'h2 :
                          state_reg == fllcg_pkg::ST_FEE ? 2'h3 : 2'h0;
   wire lock_flag = locked_reg && in_loop;
   wire [7:0] rd_status = {2'h0, stable_reg, ext_ready, loss_reg,
                           lock_flag, mode_code};
   wire [7:0] rd_mux =
      addr == fllcg_pkg::OFS_CTRL    ? {3'h0, keep_reg, range_reg,
                                        refsel_reg, mode_sel_reg} :
      addr == fllcg_pkg::OFS_LOOP    ? {1'b0, divr_reg, 1'b0, mult_reg} :
      addr == fllcg_pkg::OFS_STATUS  ? rd_status :
      addr == fllcg_pkg::OFS_FILT_HI ? {4'h0, filter_reg[11:8]} :
      addr == fllcg_pkg::OFS_FILT_LO ? filter_reg[7:0] :
      addr == fllcg_pkg::OFS_TRIM    ? trim_reg : 8'h00;

   // mode transitions; stop takes priority over every other cause
   always_comb begin
      state_next = state_reg;
      if (go_off) begin
         state_next = fllcg_pkg::ST_OFF;
      end else begin
         unique case (state_reg)
            fllcg_pkg::ST_OFF: begin
               if (mode_sel_reg == fllcg_pkg::SEL_BYPASS && ext_at_off_reg)
                  state_next = fllcg_pkg::ST_FBE;
               else
                  state_next = fllcg_pkg::ST_SCM;
            end
            fllcg_pkg::ST_SCM: begin
               // with select 01 only an off exit waits for a steady oscillator; 11 always waits
               if (mode_sel_reg == fllcg_pkg::SEL_INT_LOCK &&
                   (stable_reg || !off_exit_reg))
                  state_next = fllcg_pkg::ST_FEI;
               else if (mode_sel_reg == fllcg_pkg::SEL_EXT_LOCK &&
                        stable_reg)
                  state_next = ext_ready ? fllcg_pkg::ST_FEE
                                         : fllcg_pkg::ST_FEI;
               else if (mode_sel_reg == fllcg_pkg::SEL_BYPASS &&
                        ext_ready)
                  state_next = fllcg_pkg::ST_FBE;
            end
            fllcg_pkg::ST_FEI: begin
               if (mode_sel_reg == fllcg_pkg::SEL_SELF || lost_ext)
                  state_next = fllcg_pkg::ST_SCM;
               else if (mode_sel_reg == fllcg_pkg::SEL_BYPASS)
                  state_next = fllcg_pkg::ST_SCM;
               else if (mode_sel_reg == fllcg_pkg::SEL_EXT_LOCK &&
                        ext_ready && stable_reg)
                  state_next = fllcg_pkg::ST_FEE;
            end
            fllcg_pkg::ST_FEE: begin
               if (loss_event && ext_ready)
                  state_next = fllcg_pkg::ST_FBE;
               else if (mode_sel_reg == fllcg_pkg::SEL_SELF || lost_ext)
                  state_next = fllcg_pkg::ST_SCM;
               else if (mode_sel_reg == fllcg_pkg::SEL_INT_LOCK)
                  state_next = fllcg_pkg::ST_FEI;
               else if (mode_sel_reg == fllcg_pkg::SEL_BYPASS)
                  state_next = fllcg_pkg::ST_SCM;
            end
            fllcg_pkg::ST_FBE: begin
               if (mode_sel_reg != fllcg_pkg::SEL_BYPASS || lost_ext)
                  state_next = fllcg_pkg::ST_SCM;
            end
            default: state_next = fllcg_pkg::ST_SCM;
         endcase
      end
   end

   // filter: direct write when open, per-sample step when unlocked,
   // averaged step every fourth sample when locked
   always_comb begin
      filter_next = filter_reg;
      if (wr_fhi && filt_open)
         filter_next = {wdata[3:0], filt_stage_reg};
      else if (in_loop && err_valid && !locked_reg)
         filter_next = filter_reg - 12'(count_err);
      else if (in_loop && err_valid && avg_cnt_reg == fllcg_pkg::AVG_LAST)
         filter_next = filter_reg - 12'(avg_sum >>> 2);
   end

   always_ff @(posedge clock) begin
      if (rst) begin
         state_reg    <= fllcg_pkg::ST_SCM;
         mode_sel_reg <= fllcg_pkg::MODE_SEL_RESET;
         refsel_reg   <= 1'b0;
         range_reg    <= 1'b0;
         keep_reg     <= 1'b0;
         mult_reg     <= fllcg_pkg::MULT_RESET;
         divr_reg     <= fllcg_pkg::DIVR_RESET;
         filter_reg   <= fllcg_pkg::FILTER_RESET;
         filt_stage_reg <= 8'h00;
      end else begin
         state_reg  <= state_next;
         filter_reg <= filter_next;
         if (wr_flo && filt_open)
            filt_stage_reg <= wdata;
         if (wr_ctrl) begin
            mode_sel_reg <= wdata[fllcg_pkg::CTRL_MODE_LSB +: 2];
            refsel_reg   <= wdata[fllcg_pkg::CTRL_REFSEL];
            range_reg    <= wdata[fllcg_pkg::CTRL_RANGE];
            keep_reg     <= wdata[fllcg_pkg::CTRL_KEEP];
         end else if (state_reg == fllcg_pkg::ST_FEE &&
                      state_next == fllcg_pkg::ST_FBE) begin
            mode_sel_reg <= fllcg_pkg::SEL_BYPASS;
         end else if (state_reg != fllcg_pkg::ST_SCM && lost_ext) begin
            mode_sel_reg <= fllcg_pkg::SEL_SELF;
         end
         if (wr_loop) begin
            mult_reg <= wdata[fllcg_pkg::LOOP_MULT_LSB +: 3];
            divr_reg <= wdata[fllcg_pkg::LOOP_DIVR_LSB +: 3];
         end
      end
   end

   // trim survives every functional reset; only power-on restores it
   always_ff @(posedge clock) begin
      if (por)
         trim_reg <= fllcg_pkg::TRIM_POR;
      else if (wr_trim)
         trim_reg <= wdata;
   end

   // status flags, crystal start-up and lock detector
   always_ff @(posedge clock) begin
      if (rst) begin
         stable_reg      <= 1'b0;
         loss_reg        <= 1'b0;
         ext_at_off_reg  <= 1'b0;
         off_exit_reg    <= 1'b0;
         locked_reg      <= 1'b0;
         ever_locked_reg <= 1'b0;
         lock_cnt_reg    <= 3'h0;
         avg_cnt_reg     <= 2'h0;
         avg_acc_reg     <= 10'sh000;
         xtal_cnt_reg    <= 13'h0000;
         rdata_reg       <= 8'h00;
      end else begin
         if (state_next == fllcg_pkg::ST_OFF)
            stable_reg <= 1'b0;
         else if (dco_stable_in)
            stable_reg <= 1'b1;
         // a new loss event wins over a simultaneous clear
         if (loss_event)
            loss_reg <= 1'b1;
         else if (wr_status && wdata[fllcg_pkg::STAT_LOSS])
            loss_reg <= 1'b0;
         if (go_off && state_reg != fllcg_pkg::ST_OFF)
            ext_at_off_reg <= ext_ready;
         if (state_reg == fllcg_pkg::ST_OFF)
            off_exit_reg <= 1'b1;
         else if (wr_ctrl || state_reg != fllcg_pkg::ST_SCM)
            off_exit_reg <= 1'b0;
         if (!ext_osc_enable || !refsel_reg)
            xtal_cnt_reg <= 13'h0000;
         else if (ext_clk_tick && !xtal_done)
            xtal_cnt_reg <= xtal_cnt_reg + 13'h0001;
         if (!in_loop || state_next != state_reg) begin
            locked_reg   <= 1'b0;
            lock_cnt_reg <= 3'h0;
            avg_cnt_reg  <= 2'h0;
            avg_acc_reg  <= 10'sh000;
            if (state_next != fllcg_pkg::ST_FEE)
               ever_locked_reg <= 1'b0;
         end else if (err_valid) begin
            if (!locked_reg) begin
               if (!in_lock_win)
                  lock_cnt_reg <= 3'h0;
               else if (lock_cnt_reg == fllcg_pkg::LOCK_SAMPLES - 3'h1)
                  begin
                  locked_reg      <= 1'b1;
                  ever_locked_reg <= 1'b1;
                  lock_cnt_reg    <= 3'h0;
               end else
                  lock_cnt_reg <= lock_cnt_reg + 3'h1;
            end else if (!in_unlock_win) begin
               locked_reg  <= 1'b0;
               avg_cnt_reg <= 2'h0;
               avg_acc_reg <= 10'sh000;
            end else begin
               avg_cnt_reg <= avg_cnt_reg + 2'h1;
               avg_acc_reg <= (avg_cnt_reg == fllcg_pkg::AVG_LAST) ?
                              10'sh000 : avg_sum;
            end
         end
         rdata_reg <= rd ? rd_mux : 8'h00;
      end
   end

   // clock path controls
   assign rdata             = rdata_reg;
   assign osc_enable        = state_reg != fllcg_pkg::ST_OFF &&
                              state_reg != fllcg_pkg::ST_FBE;
   assign irg_enable        = osc_enable;
   assign ext_osc_enable    = sel_ext && state_reg != fllcg_pkg::ST_OFF;
   assign ref_source_select = refsel_reg;
   assign ext_range_high    = range_reg;
   assign loop_closed       = in_loop;
   assign loop_ref_external = state_reg == fllcg_pkg::ST_FEE;
   assign loop_multiplier   = mult_reg;
   assign out_div_r         = divr_reg;
   assign out_from_ext      = state_reg == fllcg_pkg::ST_FBE;
   // extra halving only until the first lock in external mode
   assign out_div_by2       = state_reg == fllcg_pkg::ST_FEE &&
                              !ever_locked_reg;
   assign gen_clk_enable    = state_reg != fllcg_pkg::ST_OFF &&
                              !stop_gate &&
                              !(out_from_ext && !ext_ready);
   assign filter_value      = filter_reg;
   assign trim_value        = trim_reg;

   property p_lock_zero;
      @(posedge clock) disable iff (rst) !in_loop |-> !rd_status[2];
   endproperty
   a_lock_zero: assert property (p_lock_zero)
      else $error("lock flag set outside loop modes");
   property p_stop_off;
      @(posedge clock) disable iff (rst) go_off |=> state_reg ==
         fllcg_pkg::ST_OFF && !gen_clk_enable && !osc_enable;
   endproperty
   a_stop_off: assert property (p_stop_off)
      else $error("stop did not reach off");
   property p_debug_run;
      @(posedge clock) disable iff (rst)
         stop_req && background_debug_mode |=> state_reg !=
         fllcg_pkg::ST_OFF && gen_clk_enable | out_from_ext;
   endproperty
   a_debug_run: assert property (p_debug_run)
      else $error("debug stop halted the generator");
   property p_keep_gate;
      @(posedge clock) disable iff (rst)
         stop_gate && state_reg == fllcg_pkg::ST_SCM |->
         !gen_clk_enable && osc_enable;
   endproperty
   a_keep_gate: assert property (p_keep_gate)
      else $error("keep-in-stop gating wrong");
   property p_reset_defaults;
      @(posedge clock) rst && !por |=> state_reg == fllcg_pkg::ST_SCM &&
         filter_reg == fllcg_pkg::FILTER_RESET && $stable(trim_reg);
   endproperty
   a_reset_defaults: assert property (p_reset_defaults)
      else $error("reset defaults not loaded");
   property p_filter_locked;
      @(posedge clock) disable iff (rst)
         state_reg == fllcg_pkg::ST_SCM && !filt_open |=>
         $stable(filter_reg);
   endproperty
   a_filter_locked: assert property (p_filter_locked)
      else $error("filter changed outside open self-clocked mode");
   property p_off_unstable;
      @(posedge clock) disable iff (rst)
         state_reg == fllcg_pkg::ST_OFF |-> !stable_reg;
   endproperty
   a_off_unstable: assert property (p_off_unstable)
      else $error("stable flag set in off");
   property p_bypass_power;
      @(posedge clock) disable iff (rst)
         state_reg == fllcg_pkg::ST_FBE |->
         !osc_enable && !irg_enable && (gen_clk_enable == ext_ready ||
         stop_gate);
   endproperty
   a_bypass_power: assert property (p_bypass_power)
      else $error("bypass mode power or gating wrong");
   property p_fee_entry;
      @(posedge clock) disable iff (rst)
         state_reg == fllcg_pkg::ST_SCM && !go_off && stable_reg &&
         mode_sel_reg == fllcg_pkg::SEL_EXT_LOCK && ext_ready |=>
         state_reg == fllcg_pkg::ST_FEE;
   endproperty
   a_fee_entry: assert property (p_fee_entry)
      else $error("locked-external not entered");
   property p_osc_loss;
      @(posedge clock) disable iff (rst)
         state_reg == fllcg_pkg::ST_FEE && !go_off && !wr_ctrl &&
         loss_event && ext_ready |=> state_reg == fllcg_pkg::ST_FBE &&
         mode_sel_reg == fllcg_pkg::SEL_BYPASS;
   endproperty
   a_osc_loss: assert property (p_osc_loss)
      else $error("oscillator loss did not bypass");
endmodule : fllcg_clock_generator

// ---- sim/fllcg_ext_source.sv ----
// behavioural external clock source beside the clock generator
`timescale 1ns/10ps
module fllcg_ext_source (
   input  wire logic clock,
   input  wire logic enable,
   input  wire logic healthy,
   output logic      ext_clk_tick,
   output logic      ext_clk_ok
);
   // ticks stand still while unpowered, so a stale tick never counts
   always_ff @(posedge clock) begin
      ext_clk_tick <= enable & healthy;
      ext_clk_ok   <= enable & healthy;
   end
endmodule : fllcg_ext_source

// ---- sim/tb_fllcg_clock_generator.sv ----
// self-checking bench for the fll clock generator mode controller
`timescale 1ns/10ps
module tb_fllcg_clock_generator;
   logic              clock = 1'b0;
   logic              rst = 1'b1;
   logic              por = 1'b1;
   logic [2:0]        addr = 3'h0;
   logic [7:0]        wdata = 8'h00;
   logic              wr = 1'b0;
   logic              rd = 1'b0;
   logic              stop_req = 1'b0;
   logic              dbg = 1'b0;
   logic              stable_in = 1'b0;
   logic              healthy = 1'b0;
   logic              loss_event = 1'b0;
   logic              err_valid = 1'b0;
   logic signed [7:0] count_err = 8'sh00;
   logic [7:0]        rdata, rv, trim;
   logic              tick, ext_ok, osc_en, irg_en, ext_en, refsel, rng;
   logic              lclosed, lext, from_ext, gen_en, div2;
   logic [2:0]        mult, divr;
   logic [11:0]       filt;
   int                mismatches = 0;
   int                checks = 0;
   int                cycles = 0;
   fllcg_clock_generator i_fllcg_clock_generator (.clock, .rst, .por,
      .addr, .wdata, .wr, .rd, .rdata, .stop_req,
      .background_debug_mode(dbg), .dco_stable_in(stable_in),
      .ext_clk_ok(ext_ok), .ext_clk_tick(tick), .loss_event, .err_valid,
      .count_err, .osc_enable(osc_en), .irg_enable(irg_en),
      .ext_osc_enable(ext_en), .ref_source_select(refsel),
      .ext_range_high(rng), .loop_closed(lclosed),
      .loop_ref_external(lext), .loop_multiplier(mult), .out_div_r(divr),
      .out_from_ext(from_ext), .out_div_by2(div2), .gen_clk_enable(gen_en),
      .filter_value(filt), .trim_value(trim));
   fllcg_ext_source i_fllcg_ext_source (.clock, .enable(ext_en), .healthy,
      .ext_clk_tick(tick), .ext_clk_ok(ext_ok));
   always #2 clock = ~clock;
   // run needs about 4300 cycles, the crystal count dominates
   always @(posedge clock) begin
      cycles <= cycles + 1;
      if (cycles == 20000) begin
         mismatches++;
         conclude();
      end
   end
   task automatic conclude;
      $display("checks %0d mismatches %0d", checks, mismatches);
      if (mismatches == 0 && checks > 0) $display("RESULT: PASS");
      else $display("RESULT: FAIL");
      $finish;
   endtask : conclude
   task automatic check(input logic [11:0] seen, input logic [11:0] exp);
      checks++;
      if (seen !== exp) begin
         mismatches++;
         $display("mismatch at %0t seen %h expected %h", $time, seen, exp);
      end
   endtask : check
   task automatic wait_n(input int n);
      repeat (n) @(posedge clock);
      #1;
   endtask : wait_n
   task automatic reg_wr(input logic [2:0] a, input logic [7:0] d);
      @(posedge clock);
      addr <= a;
      wdata <= d;
      wr <= 1'b1;
      @(posedge clock);
      wr <= 1'b0;
   endtask : reg_wr
   task automatic reg_rd(input logic [2:0] a);
      @(posedge clock);
      addr <= a;
      rd <= 1'b1;
      @(posedge clock);
      rd <= 1'b0;
      #1 rv = rdata;
   endtask : reg_rd
   task automatic sample(input logic signed [7:0] e, input int n);
      repeat (n) begin
         @(posedge clock);
         err_valid <= 1'b1;
         count_err <= e;
      end
      @(posedge clock);
      err_valid <= 1'b0;
   endtask : sample
   task automatic t_reset;
      reg_rd(fllcg_pkg::OFS_STATUS);
      check(rv, 12'h000);
      check(filt, 12'h200);
      check(trim, 12'h080);
      check({gen_en, osc_en, lclosed}, 12'h006);
      check({mult, divr}, 12'h001);
      reg_rd(3'h7);
      check(rv, 12'h000);
      reg_wr(fllcg_pkg::OFS_TRIM, 8'h5a);
      reg_wr(fllcg_pkg::OFS_CTRL, 8'h01);
      @(posedge clock) rst <= 1'b1;
      @(posedge clock) rst <= 1'b0;
      reg_rd(fllcg_pkg::OFS_CTRL);
      check(trim, 12'h05a);
      check(rv, 12'h000);
      $display("test reset done");
   endtask : t_reset
   task automatic t_loop;
      reg_wr(fllcg_pkg::OFS_FILT_LO, 8'h34);
      reg_wr(fllcg_pkg::OFS_FILT_HI, 8'h05);
      wait_n(1);
      check(filt, 12'h534);
      reg_wr(fllcg_pkg::OFS_LOOP, 8'h25);
      reg_wr(fllcg_pkg::OFS_CTRL, 8'h01);
      @(posedge clock) stable_in <= 1'b1;
      @(posedge clock) stable_in <= 1'b0;
      wait_n(3);
      check({lclosed, lext}, 12'h002);
      check({mult, divr}, 12'h02a);
      reg_wr(fllcg_pkg::OFS_FILT_LO, 8'h00);
      reg_wr(fllcg_pkg::OFS_FILT_HI, 8'h00);
      reg_rd(fllcg_pkg::OFS_STATUS);
      check(filt, 12'h534);
      check({rv[5], rv[2:0]}, 12'h009);
      sample(8'sh00, 4);
      reg_rd(fllcg_pkg::OFS_STATUS);
      check(rv[2], 12'h001);
      sample(8'sh02, 4);
      wait_n(1);
      check(filt, 12'h532);
      sample(8'sh09, 1);
      reg_rd(fllcg_pkg::OFS_STATUS);
      check(rv[2], 12'h000);
      sample(8'sh03, 1);
      wait_n(1);
      check(filt, 12'h52f);
      reg_wr(fllcg_pkg::OFS_CTRL, 8'h00);
      reg_rd(fllcg_pkg::OFS_STATUS);
      check({lclosed, rv[2:0]}, 12'h000);
      $display("test loop done");
   endtask : t_loop
   task automatic t_stop;
      @(posedge clock) stop_req <= 1'b1;
      reg_rd(fllcg_pkg::OFS_STATUS);
      check({gen_en, osc_en, rv[5]}, 12'h000);
      @(posedge clock) dbg <= 1'b1;
      wait_n(3);
      check({gen_en, osc_en}, 12'h003);
      @(posedge clock) dbg <= 1'b0;
      stop_req <= 1'b0;
      reg_wr(fllcg_pkg::OFS_CTRL, 8'h10);
      @(posedge clock) stop_req <= 1'b1;
      wait_n(3);
      check({gen_en, osc_en}, 12'h001);
      @(posedge clock) stop_req <= 1'b0;
      wait_n(3);
      check(gen_en, 12'h001);
      $display("test stop done");
   endtask : t_stop
   task automatic t_bypass;
      @(posedge clock) healthy <= 1'b1;
      reg_wr(fllcg_pkg::OFS_CTRL, 8'h0e);
      wait_n(4000);
      check({refsel, rng, from_ext}, 12'h006);
      wait_n(200);
      check({from_ext, osc_en, irg_en}, 12'h004);
      @(posedge clock) healthy <= 1'b0;
      loss_event <= 1'b1;
      @(posedge clock) loss_event <= 1'b0;
      wait_n(4);
      reg_rd(fllcg_pkg::OFS_STATUS);
      check({rv[3], rv[1:0]}, 12'h004);
      reg_wr(fllcg_pkg::OFS_STATUS, 8'h08);
      reg_rd(fllcg_pkg::OFS_STATUS);
      check(rv[3], 12'h000);
      $display("test bypass done");
   endtask : t_bypass
   task automatic t_external;
      @(posedge clock) healthy <= 1'b1;
      reg_wr(fllcg_pkg::OFS_CTRL, 8'h03);
      @(posedge clock) stable_in <= 1'b1;
      @(posedge clock) stable_in <= 1'b0;
      wait_n(3);
      reg_rd(fllcg_pkg::OFS_STATUS);
      check(rv, 12'h033);
      check({lclosed, lext, div2}, 12'h007);
      @(posedge clock) loss_event <= 1'b1;
      @(posedge clock) loss_event <= 1'b0;
      wait_n(2);
      check({from_ext, osc_en, gen_en}, 12'h005);
      reg_rd(fllcg_pkg::OFS_CTRL);
      check(rv, 12'h002);
      $display("test external done");
   endtask : t_external
   initial begin
      repeat (10) @(posedge clock);
      rst <= 1'b0;
      por <= 1'b0;
      t_reset();
      t_loop();
      t_stop();
      t_bypass();
      t_external();
      conclude();
   end
endmodule : tb_fllcg_clock_generator
